// file: logic/fan_ramp_pkg.sv
// Constants, register map and increment decode for the fan drive ramp block
package fan_ramp_pkg;
   localparam int DUTY_W = 8;
   localparam logic [7:0] ADDR_ACOUSTIC = 8'h62;
   localparam logic [7:0] ADDR_STATUS = 8'h70;
   localparam logic [7:0] ACOUSTIC_RESET = 8'h00;
   localparam logic [7:0] DUTY_RESET = 8'h00;
   localparam logic [7:0] DUTY_OFF = 8'h00;
   localparam int RATE_LSB = 0;
   localparam int RATE_MSB = 2;
   localparam int RAMP_EN_BIT = 3;
   localparam int SYNC_BIT = 4;
   localparam int FLOOR1_BIT = 5;
   localparam int FLOOR2_BIT = 6;
   localparam int FLOOR3_BIT = 7;
   localparam int STATUS_BUSY_BIT = 0;
   localparam int CLOCK_HZ = 20_000_000;
   localparam int SLOT_TIME_US = 205_000;
   localparam int SLOT_CYCLES = (SLOT_TIME_US / 1000) * (CLOCK_HZ / 1000);

   typedef enum logic [0:0] {
      RAMP_HOLD = 1'b0,
      RAMP_STEP = 1'b1
   } ramp_state_t;

   // Duty increment applied per time slot for each rate code
   function automatic logic [7:0] ramp_increment(input logic [2:0] code);
      logic [7:0] inc;
      inc = 8'h01;
      case (code)
         3'h0: inc = 8'h01;
         3'h1: inc = 8'h02;
         3'h2: inc = 8'h03;
         3'h3: inc = 8'h04;
         3'h4: inc = 8'h08;
         3'h5: inc = 8'h0c;
         3'h6: inc = 8'h18;
         3'h7: inc = 8'h30;
         default: inc = 8'h01;
      endcase
      return inc;
   endfunction
endpackage

// file: logic/ramp_if.sv
// Carrier between the control register logic and the duty ramp stepper
`timescale 1ns/10ps
interface ramp_if;
   logic [7:0] target;
   logic ramp_en;
   logic [2:0] rate_code;
   logic slot;
   logic [7:0] applied;
   logic busy;
   modport ctl (output target, ramp_en, rate_code, slot, input applied, busy);
   modport rmp (input target, ramp_en, rate_code, slot, output applied, busy);
endinterface

// file: logic/tach_sync.sv
// Three-stage pin synchroniser for one fan speed input
`timescale 1ns/10ps
module tach_sync (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic pin,
   output logic level
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic level_q;
   logic agree;

   assign agree = (s2_q == s3_q);
   assign level = level_q;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         level_q <= 1'b0;
      end else begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (agree) begin
            level_q <= s3_q;
         end
      end
   end
endmodule

// file: logic/duty_ramp.sv
// Duty stepper that walks the applied duty toward its target once per slot
`timescale 1ns/10ps
module duty_ramp (
   input wire logic clk,
   input wire logic rst_n,
   ramp_if.rmp rif
);
   fan_ramp_pkg::ramp_state_t state_q;
   logic [7:0] applied_q;
   logic [7:0] inc;
   logic [7:0] diff_up;
   logic [7:0] diff_dn;
   logic [7:0] step_up;
   logic [7:0] step_dn;
   logic [7:0] applied_d;
   fan_ramp_pkg::ramp_state_t state_d;

   assign inc = fan_ramp_pkg::ramp_increment(rif.rate_code);
   assign diff_up = rif.target - applied_q;
   assign diff_dn = applied_q - rif.target;
   assign step_up = (diff_up < inc) ? rif.target : applied_q + inc;
   assign step_dn = (diff_dn < inc) ? rif.target : applied_q - inc;
   assign applied_d = !rif.ramp_en ? rif.target :
                      !rif.slot ? applied_q :
                      (applied_q < rif.target) ? step_up :
                      (applied_q > rif.target) ? step_dn : applied_q;
   assign state_d = (rif.ramp_en && (applied_d != rif.target)) ?
                    fan_ramp_pkg::RAMP_STEP : fan_ramp_pkg::RAMP_HOLD;
   assign rif.applied = applied_q;
   assign rif.busy = (state_q == fan_ramp_pkg::RAMP_STEP);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         applied_q <= fan_ramp_pkg::DUTY_RESET;
         state_q <= fan_ramp_pkg::RAMP_HOLD;
      end else begin
         applied_q <= applied_d;
         state_q <= state_d;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   direct_jump_a: assert property (!rif.ramp_en |=> applied_q == $past(rif.target))
      else $error("Applied duty did not jump to target with ramp off");
   step_size_a: assert property ((rif.ramp_en && rif.slot && applied_q < rif.target
      && (rif.target - applied_q) >= inc) |=> applied_q == $past(applied_q) + $past(inc))
      else $error("Ramp step differs from selected increment");
   no_overshoot_a: assert property ((rif.ramp_en && rif.slot && applied_q < rif.target)
      |=> (applied_q <= $past(rif.target)) && (applied_q > $past(applied_q)))
      else $error("Ramp overshot or stalled on the way up");
   slot_hold_a: assert property ((rif.ramp_en && !rif.slot) |=> $stable(applied_q))
      else $error("Applied duty moved between slots while ramping");
endmodule

// file: logic/fan_drive_ramp_control.sv
// Acoustic ramp control register with drive duty selection and tach sync
//
// Function
// - Three-bit field picks drive 1 ramp rate; ramping walks duty toward new target.
// - Rate codes 0..7 step the duty by 1,2,3,4,8,12,24,48 per time slot.
// - Bit 3 enables drive 1 ramping; otherwise duty jumps straight to target.
// - Sync bit 4 set synchronises speed inputs 2, 3 and 4 to drive 3.
// - Sync bit clear synchronises only speed inputs 3 and 4 to drive 3.
// - Auto mode below threshold: bit 5 picks zero or floor duty for drive 1.
// - Auto mode below threshold: bit 6 picks zero or floor duty for drive 2.
// - Auto mode below threshold: bit 7 picks zero or floor duty for drive 3.
// - The acoustic control register resets to all zeros.
// - With the configuration lock set, writes to the register are ignored.
//
// Our own choice: the plain strobed port.
`timescale 1ns/10ps
module fan_drive_ramp_control #(
   parameter int SLOT_CYCLES = fan_ramp_pkg::SLOT_CYCLES
) (
   input wire logic CLOCK,
   input wire logic RST_B,
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [7:0] REG_RDATA,
   input wire logic CONFIG_LOCK,
   input wire logic [7:0] CALC_DUTY_1,
   input wire logic [7:0] CALC_DUTY_2,
   input wire logic [7:0] CALC_DUTY_3,
   input wire logic [7:0] FLOOR_DUTY_1,
   input wire logic [7:0] FLOOR_DUTY_2,
   input wire logic [7:0] FLOOR_DUTY_3,
   input wire logic [2:0] AUTO_MODE,
   input wire logic [2:0] BELOW_THRESHOLD,
   input wire logic FAN_DRIVE_3_LEVEL,
   input wire logic FAN_SPEED_INPUT_2,
   input wire logic FAN_SPEED_INPUT_3,
   input wire logic FAN_SPEED_INPUT_4,
   output logic [7:0] FAN_DRIVE_1,
   output logic [7:0] FAN_DRIVE_2,
   output logic [7:0] FAN_DRIVE_3,
   output logic [2:0] SPEED_PIN,
   output logic [2:0] SPEED_GATE
);
   if (SLOT_CYCLES < 2) begin : slot_check
      $error("SLOT_CYCLES must be at least two for a one-cycle slot pulse");
   end

   ramp_if rif ();

   logic [7:0] acoustic_q;
   logic [7:0] rdata_q;
   logic [7:0] drive2_q;
   logic [7:0] drive3_q;
   logic [2:0] gate_q;
   logic [2:0] pin_q;
   logic [31:0] slot_cnt_q;
   logic slot_q;
   logic [2:0] speed_lvl;
   logic [2:0] synced;
   logic wr_acoustic;
   logic slot_end;
   logic [7:0] target1;
   logic [7:0] target2;
   logic [7:0] target3;
   logic [7:0] status_word;
   logic [7:0] read_mux;
   logic drive1_ramp_enable;
   logic drive1_below_floor_select;
   logic drive2_below_floor_select;
   logic drive3_below_floor_select;
   logic speed_sync_all;

   // Register field views
   assign drive1_ramp_enable = acoustic_q[fan_ramp_pkg::RAMP_EN_BIT];
   assign speed_sync_all = acoustic_q[fan_ramp_pkg::SYNC_BIT];
   assign drive1_below_floor_select = acoustic_q[fan_ramp_pkg::FLOOR1_BIT];
   assign drive2_below_floor_select = acoustic_q[fan_ramp_pkg::FLOOR2_BIT];
   assign drive3_below_floor_select = acoustic_q[fan_ramp_pkg::FLOOR3_BIT];

   // Register write decode, blocked by the configuration lock
   assign wr_acoustic = REG_WR && !CONFIG_LOCK &&
                        (REG_ADDR == fan_ramp_pkg::ADDR_ACOUSTIC);

   // Below-threshold duty choice in automatic mode
   assign target1 = (AUTO_MODE[0] && BELOW_THRESHOLD[0]) ?
      (drive1_below_floor_select ? FLOOR_DUTY_1 : fan_ramp_pkg::DUTY_OFF) :
      CALC_DUTY_1;
   assign target2 = (AUTO_MODE[1] && BELOW_THRESHOLD[1]) ?
      (drive2_below_floor_select ? FLOOR_DUTY_2 : fan_ramp_pkg::DUTY_OFF) :
      CALC_DUTY_2;
   assign target3 = (AUTO_MODE[2] && BELOW_THRESHOLD[2]) ?
      (drive3_below_floor_select ? FLOOR_DUTY_3 : fan_ramp_pkg::DUTY_OFF) :
      CALC_DUTY_3;

   // Ramp stepper hookup for drive 1
   assign rif.target = target1;
   assign rif.ramp_en = drive1_ramp_enable;
   assign rif.rate_code = acoustic_q[fan_ramp_pkg::RATE_MSB:fan_ramp_pkg::RATE_LSB];
   assign rif.slot = slot_q;

   duty_ramp ramp1 (
      .clk(CLOCK),
      .rst_n(RST_B),
      .rif(rif)
   );

   // Time slot divider, one-cycle enable pulse
   assign slot_end = (slot_cnt_q == 32'(SLOT_CYCLES - 1));

   // Speed input synchronisers
   tach_sync sync2 (
      .clk(CLOCK),
      .rst_n(RST_B),
      .pin(FAN_SPEED_INPUT_2),
      .level(speed_lvl[0])
   );
   tach_sync sync3 (
      .clk(CLOCK),
      .rst_n(RST_B),
      .pin(FAN_SPEED_INPUT_3),
      .level(speed_lvl[1])
   );
   tach_sync sync4 (
      .clk(CLOCK),
      .rst_n(RST_B),
      .pin(FAN_SPEED_INPUT_4),
      .level(speed_lvl[2])
   );

   // Which speed inputs are gated by drive 3
   assign synced = {1'b1, 1'b1, speed_sync_all};

   // Status and read selection
   assign status_word = {7'h00, rif.busy};
   assign read_mux = (REG_ADDR == fan_ramp_pkg::ADDR_ACOUSTIC) ? acoustic_q :
                     (REG_ADDR == fan_ramp_pkg::ADDR_STATUS) ? status_word : 8'h00;

   always_ff @(posedge CLOCK) begin
      if (!RST_B) begin
         acoustic_q <= fan_ramp_pkg::ACOUSTIC_RESET;
      end else if (wr_acoustic) begin
         acoustic_q <= REG_WDATA;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (!RST_B) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= REG_RD ? read_mux : 8'h00;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (!RST_B) begin
         slot_cnt_q <= 32'h0;
         slot_q <= 1'b0;
      end else begin
         slot_cnt_q <= slot_end ? 32'h0 : slot_cnt_q + 32'h1;
         slot_q <= slot_end;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (!RST_B) begin
         drive2_q <= fan_ramp_pkg::DUTY_RESET;
         drive3_q <= fan_ramp_pkg::DUTY_RESET;
      end else begin
         drive2_q <= target2;
         drive3_q <= target3;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (!RST_B) begin
         gate_q <= 3'h0;
         pin_q <= 3'h0;
      end else begin
         gate_q <= ~synced | {3{FAN_DRIVE_3_LEVEL}};
         pin_q <= speed_lvl;
      end
   end

   assign REG_RDATA = rdata_q;
   assign FAN_DRIVE_1 = rif.applied;
   assign FAN_DRIVE_2 = drive2_q;
   assign FAN_DRIVE_3 = drive3_q;
   assign SPEED_PIN = pin_q;
   assign SPEED_GATE = gate_q;

   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_B);

   sequence locked_write_s;
      CONFIG_LOCK && REG_WR && REG_ADDR == fan_ramp_pkg::ADDR_ACOUSTIC;
   endsequence

   lock_hold_a: assert property (locked_write_s |=> $stable(acoustic_q))
      else $error("Locked control register changed on write");
   write_take_a: assert property (wr_acoustic |=> acoustic_q == $past(REG_WDATA))
      else $error("Unlocked write not stored");
   reset_zero_a: assert property (disable iff (1'b0) !RST_B |=> acoustic_q == 8'h00)
      else $error("Control register not zero after reset");
   floor1_sel_a: assert property ((AUTO_MODE[0] && BELOW_THRESHOLD[0] && !drive1_ramp_enable)
      |=> FAN_DRIVE_1 == ($past(drive1_below_floor_select) ? $past(FLOOR_DUTY_1) : 8'h00))
      else $error("Drive 1 below-threshold duty wrong");
   floor2_sel_a: assert property ((AUTO_MODE[1] && BELOW_THRESHOLD[1])
      |=> FAN_DRIVE_2 == ($past(drive2_below_floor_select) ? $past(FLOOR_DUTY_2) : 8'h00))
      else $error("Drive 2 below-threshold duty wrong");
   floor3_sel_a: assert property ((AUTO_MODE[2] && BELOW_THRESHOLD[2])
      |=> FAN_DRIVE_3 == ($past(drive3_below_floor_select) ? $past(FLOOR_DUTY_3) : 8'h00))
      else $error("Drive 3 below-threshold duty wrong");
   sync_all_a: assert property ((speed_sync_all && !FAN_DRIVE_3_LEVEL)
      |=> SPEED_GATE == 3'h0)
      else $error("Speed input 2 not gated by drive 3");
   sync_two_a: assert property ((!speed_sync_all && !FAN_DRIVE_3_LEVEL)
      |=> SPEED_GATE == 3'h1)
      else $error("Speed input 2 gated while sync bit clear");
   slot_pulse_a: assert property (slot_q |=> !slot_q)
      else $error("Time slot pulse longer than one cycle");
endmodule

// file: verification/fan_model.sv
// Fans on the speed inputs: open-drain tach lines that pulse while spinning
`timescale 1ns/10ps
module fan_model #(
   parameter int HALF_NS = 1337
) (
   input wire logic [2:0] run,
   output logic [2:0] tach
);
   initial tach = 3'h7;
   for (genvar i = 0; i < 3; i++) begin : g_fan
      // Stopped fan releases the line to its pull-up
      always begin
         #(HALF_NS + 100 * i);
         if (run[i] === 1'b1) tach[i] = ~tach[i];
         else tach[i] = 1'b1;
      end
   end
endmodule

// file: verification/tb_top.sv
// Self-checking bench for the fan drive ramp control block
`timescale 1ns/10ps
module tb_top;
   logic clk = 1'b0, rst_b = 1'b0, wr_s = 1'b0, rd_s = 1'b0, lock = 1'b0, drv3 = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d1, d2, d3;
   logic [7:0] c1 = 8'h00, c2 = 8'h00, c3 = 8'h00, f1 = 8'h11, f2 = 8'h22, f3 = 8'h33;
   logic [2:0] auto_m = 3'h0, below = 3'h0, run = 3'h0, tach, pin, gate;
   logic [7:0] inc_tab [8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h0c, 8'h18, 8'h30};
   int err_count = 0, comparisons = 0;
   always #25 clk = ~clk;
   fan_drive_ramp_control #(.SLOT_CYCLES(4)) i_fan_drive_ramp_control (.CLOCK(clk),
      .RST_B(rst_b), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr_s), .REG_RD(rd_s),
      .REG_RDATA(rdata), .CONFIG_LOCK(lock), .CALC_DUTY_1(c1), .CALC_DUTY_2(c2),
      .CALC_DUTY_3(c3), .FLOOR_DUTY_1(f1), .FLOOR_DUTY_2(f2), .FLOOR_DUTY_3(f3),
      .AUTO_MODE(auto_m), .BELOW_THRESHOLD(below), .FAN_DRIVE_3_LEVEL(drv3),
      .FAN_SPEED_INPUT_2(tach[0]), .FAN_SPEED_INPUT_3(tach[1]), .FAN_SPEED_INPUT_4(tach[2]),
      .FAN_DRIVE_1(d1), .FAN_DRIVE_2(d2), .FAN_DRIVE_3(d3), .SPEED_PIN(pin), .SPEED_GATE(gate));
   fan_model i_fan_model (.run(run), .tach(tach));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr_s <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      rd_s <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_s <= 1'b0;
      #1;
      check(rdata, exp);
   endtask
   task automatic t_regs();
      rd(8'h62, 8'h00);
      check(d1, 8'h00);
      wr(8'h62, 8'ha5);
      rd(8'h62, 8'ha5);
      @(posedge clk);
      lock <= 1'b1;
      wr(8'h62, 8'h5a);
      rd(8'h62, 8'ha5);
      @(posedge clk);
      lock <= 1'b0;
      rd(8'h11, 8'h00);
      wr(8'h62, 8'h00);
   endtask
   task automatic t_floor();
      logic [7:0] f;
      c1 <= 8'h40;
      c2 <= 8'h41;
      c3 <= 8'h42;
      repeat (3) @(posedge clk);
      #1;
      check(d1, 8'h40);
      @(posedge clk);
      auto_m <= 3'h7;
      below <= 3'h7;
      for (int i = 0; i < 8; i++) begin
         f = 8'(i);
         wr(8'h62, f << 5);
         repeat (3) @(posedge clk);
         #1;
         check(d1, f[0] ? 8'h11 : 8'h00);
         check(d2, f[1] ? 8'h22 : 8'h00);
         check(d3, f[2] ? 8'h33 : 8'h00);
      end
      @(posedge clk);
      below <= 3'h0;
      repeat (3) @(posedge clk);
      #1;
      check(d3, 8'h42);
      @(posedge clk);
      auto_m <= 3'h0;
   endtask
   task automatic ramp_walk(input logic [2:0] code, input logic [7:0] tgt);
      logic [7:0] cur, inc, exp;
      int n;
      inc = inc_tab[code];
      wr(8'h62, {5'h01, code});
      c1 <= tgt;
      cur = d1;
      if (tgt > cur) rd(8'h70, 8'h01);
      while (cur !== tgt && err_count < 50) begin
         n = 0;
         while (d1 === cur && n < 40) begin
            @(posedge clk);
            #1;
            n++;
         end
         if (tgt > cur) exp = (tgt - cur > inc) ? cur + inc : tgt;
         else exp = (cur - tgt > inc) ? cur - inc : tgt;
         check(d1, exp);
         cur = d1;
      end
      repeat (12) @(posedge clk);
      #1;
      check(d1, tgt);
      rd(8'h70, 8'h00);
   endtask
   task automatic t_ramp();
      for (int c = 0; c < 8; c++) begin
         wr(8'h62, 8'h00);
         c1 <= 8'h00;
         repeat (3) @(posedge clk);
         ramp_walk(3'(c), 8'h31);
      end
      ramp_walk(3'h7, 8'h02);
   endtask
   task automatic t_sync();
      int n;
      for (int s = 0; s < 2; s++) begin
         for (int l = 0; l < 2; l++) begin
            wr(8'h62, 8'(s << 4));
            drv3 <= 1'(l);
            repeat (3) @(posedge clk);
            #1;
            if (s == 1) check({5'h00, gate}, {5'h00, {3{1'(l)}}});
            else check({5'h00, gate}, {5'h00, 1'(l), 1'(l), 1'b1});
         end
      end
      repeat (8) @(posedge clk);
      #1;
      check({5'h00, pin}, 8'h07);
      @(posedge clk);
      run <= 3'h7;
      n = 0;
      while (tach[0] === 1'b1 && n < 100) begin
         @(posedge clk);
         n++;
      end
      repeat (7) @(posedge clk);
      #1;
      check({7'h00, pin[0]}, 8'h00);
   endtask
   task automatic t_reset();
      wr(8'h62, 8'hff);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      rd(8'h62, 8'h00);
      check(d1, 8'h02);
   endtask
   task automatic results();
      $display("comparisons %0d, mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      results();
   end
   initial begin
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      t_regs();
      t_floor();
      t_ramp();
      t_sync();
      t_reset();
      results();
   end
endmodule
